// file: hdl/slip_pkg.sv
// Purpose: Shared constants for the strap latch and interrupt pin block.
// Assumes: 32-bit AXI4-Lite register words, one word per register index.
// Notes:   Byte address of a register is four times its index.
package slip_pkg;

	// ==========================================================
	// Register indices and byte addresses
	localparam logic [4:0] IDX_STRAP    = 5'h10;
	localparam logic [4:0] IDX_WAKE_CFG = 5'h11;
	localparam logic [4:0] IDX_INT_CTRL = 5'h1B;
	localparam logic [4:0] IDX_PHY_CTRL = 5'h1F;
	localparam int         ADDR_W       = 8;
	localparam int         IDX_LSB      = 2;
	localparam int         IDX_MSB      = 6;

	// ==========================================================
	// Field positions
	localparam int EVT_LINK    = 0;
	localparam int EVT_WAKE    = 1;
	localparam int EVT_MGMT    = 2;
	localparam int EVT_W       = 3;
	localparam int INT_EN_LSB  = 8;
	localparam int POL_BIT     = 14;
	localparam int WAKE_SEL_BIT = 0;
	localparam int STRAP_CLKEN = 4;
	localparam int STRAP_LED   = 5;
	localparam int STRAP_ADDR  = 6;

	// ==========================================================
	// Strap decode values
	localparam logic [3:0] MODE_NAND_TREE  = 4'h4;
	localparam logic [3:0] MODE_POWER_DOWN = 4'h7;
	localparam logic [1:0] MGMT_ADDR_HIGH  = 2'h0;

	// ==========================================================
	// Management frame layout
	localparam logic [5:0] PREAMBLE_LEN = 6'h20;
	localparam logic [4:0] HDR_BITS     = 5'h0D;
	localparam logic [4:0] DATA_BITS    = 5'h10;
	localparam logic [4:0] SKIP_BITS    = 5'h12;
	localparam logic [1:0] OP_READ      = 2'h2;
	localparam logic [1:0] OP_WRITE     = 2'h1;

	// ==========================================================
	// Bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		MG_PREAMBLE,
		MG_HEADER,
		MG_TURN,
		MG_DATA,
		MG_SKIP
	} slip_mgmt_state_type;

endpackage

// file: hdl/slip_sync.sv
// Purpose: Two-flop synchroniser for pins from outside the clock domain.
// Assumes: Inputs are levels that stay stable for several clock periods.
// Notes:   No reset, so pin levels are tracked while the block is in reset.
`timescale 1ns/10ps
`default_nettype none
module slip_sync #(
	parameter int WIDTH = 1
) (
	// Clock
	input  wire logic             clk,
	// Levels
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] sync_reg;

	// The strap capture needs the pin level present during reset, so the
	// chain is deliberately left unreset.
	always_ff @(posedge clk) begin
		meta_reg <= async_in;
		sync_reg <= meta_reg;
	end

	assign sync_out = sync_reg;

endmodule
`default_nettype wire

// file: hdl/slip_top.sv
// Purpose: Strap capture on shared receive pins, interrupt/wake pin,
//          reference clock pin and management frame responder.
// Assumes: aresetn stands for the chip reset; straps are caught at its
//          release. Pin data sources are on aclk.
// Notes:   Registers are reached over AXI4-Lite and by management frames.
`timescale 1ns/10ps
`default_nettype none
module slip_top
	import slip_pkg::*;
(
	// Clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// AXI4-Lite slave
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// Receive-side data sources inside the device
	input  wire logic [3:0]        rx_data,
	input  wire logic              rx_ctl,
	input  wire logic              rx_clk_src,
	input  wire logic              ref_clk_src,
	input  wire logic [1:0]        mgmt_addr_low,
	// Event pulses
	input  wire logic              link_event,
	input  wire logic              wake_event,
	// Shared receive pins
	input  wire logic [3:0]        rxd_pin_in,
	output logic      [3:0]        rxd_pin_out,
	output logic      [3:0]        rxd_pin_oe,
	input  wire logic              rx_ctl_pin_in,
	output logic                   rx_ctl_pin_out,
	output logic                   rx_ctl_pin_oe,
	input  wire logic              rxc_pin_in,
	output logic                   rxc_pin_out,
	output logic                   rxc_pin_oe,
	input  wire logic              ref_clock_out_pin_in,
	output logic                   ref_clock_out,
	output logic                   ref_clock_out_oe,
	// Management pins
	input  wire logic              mdc,
	input  wire logic              mdio_in,
	output logic                   mdio_out,
	output logic                   mdio_oe,
	// Interrupt and status outputs
	output logic                   wake_event_out_n,
	output logic                   irq,
	output logic [4:0]             mgmt_address,
	output logic                   nand_tree_mode,
	output logic                   chip_power_down,
	output logic                   led_indication_select,
	output logic                   strap_done
);

	// ==========================================================
	// Pin synchronisers
	logic [6:0] strap_sync;
	logic [1:0] mgmt_sync;
	logic       mdc_d_reg;

	slip_sync #(.WIDTH(7)) u_strap_sync (
		.clk      (aclk),
		.async_in ({ref_clock_out_pin_in, rxc_pin_in, rx_ctl_pin_in,
		            rxd_pin_in}),
		.sync_out (strap_sync)
	);

	slip_sync #(.WIDTH(2)) u_mgmt_sync (
		.clk      (aclk),
		.async_in ({mdc, mdio_in}),
		.sync_out (mgmt_sync)
	);

	// ==========================================================
	// Strap capture
	logic       captured_reg;
	logic       op_mode_strap_bit0_reg;
	logic       op_mode_strap_bit1_reg;
	logic       op_mode_strap_bit2_reg;
	logic       op_mode_strap_bit3_reg;
	logic       ref_clock_out_enable_strap_reg;
	logic       mgmt_address_strap_bit2_reg;
	logic       led_indication_select_strap_reg;
	logic [3:0] mode_vec;

	assign mode_vec = {op_mode_strap_bit3_reg, op_mode_strap_bit2_reg,
	                   op_mode_strap_bit1_reg, op_mode_strap_bit0_reg};

	always_ff @(posedge aclk) begin
		captured_reg <= aresetn;
	end

	// The first edge with reset released is the capture edge; afterwards
	// the values are held until reset comes again.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			op_mode_strap_bit0_reg          <= 1'h0;
			op_mode_strap_bit1_reg          <= 1'h0;
			op_mode_strap_bit2_reg          <= 1'h0;
			op_mode_strap_bit3_reg          <= 1'h0;
			ref_clock_out_enable_strap_reg  <= 1'h0;
			mgmt_address_strap_bit2_reg     <= 1'h0;
			led_indication_select_strap_reg <= 1'h0;
		end else if (!captured_reg) begin
			op_mode_strap_bit0_reg          <= strap_sync[0];
			op_mode_strap_bit1_reg          <= strap_sync[1];
			op_mode_strap_bit2_reg          <= strap_sync[2];
			op_mode_strap_bit3_reg          <= strap_sync[3];
			ref_clock_out_enable_strap_reg  <= strap_sync[4];
			mgmt_address_strap_bit2_reg     <= strap_sync[5];
			led_indication_select_strap_reg <= strap_sync[6];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			nand_tree_mode        <= 1'h0;
			chip_power_down       <= 1'h0;
			mgmt_address          <= '0;
			led_indication_select <= 1'h0;
			strap_done            <= 1'h0;
		end else begin
			nand_tree_mode  <= captured_reg && (mode_vec == MODE_NAND_TREE);
			chip_power_down <= captured_reg && (mode_vec == MODE_POWER_DOWN);
			mgmt_address    <= {MGMT_ADDR_HIGH, mgmt_address_strap_bit2_reg,
			                    mgmt_addr_low};
			led_indication_select <= led_indication_select_strap_reg;
			strap_done            <= captured_reg;
		end
	end

	// ==========================================================
	// Shared pin drive
	// Pin levels only mirror the aclk-side sources; a true 125 MHz clock
	// must come through ref_clk_src from the device clock generator.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rxd_pin_oe       <= '0;
			rx_ctl_pin_oe    <= 1'h0;
			rxc_pin_oe       <= 1'h0;
			ref_clock_out_oe <= 1'h0;
			rxd_pin_out      <= '0;
			rx_ctl_pin_out   <= 1'h0;
			rxc_pin_out      <= 1'h0;
			ref_clock_out    <= 1'h0;
		end else begin
			rxd_pin_oe       <= '1;
			rx_ctl_pin_oe    <= 1'h1;
			rxc_pin_oe       <= 1'h1;
			ref_clock_out_oe <= captured_reg &&
			                    ref_clock_out_enable_strap_reg;
			rxd_pin_out      <= rx_data;
			rx_ctl_pin_out   <= rx_ctl;
			rxc_pin_out      <= rx_clk_src;
			ref_clock_out    <= ref_clk_src;
		end
	end

	// ==========================================================
	// Control and interrupt registers
	logic [EVT_W-1:0] int_status_reg;
	logic [EVT_W-1:0] int_en_reg;
	logic [EVT_W-1:0] evt_set;
	logic [EVT_W-1:0] evt_clr;
	logic             pol_reg;
	logic             wake_sel_reg;
	logic             mgmt_evt;
	logic             irq_active;

	function automatic logic is_mapped(input logic [4:0] idx);
		is_mapped = (idx == IDX_STRAP) || (idx == IDX_WAKE_CFG) ||
		            (idx == IDX_INT_CTRL) || (idx == IDX_PHY_CTRL);
	endfunction

	function automatic logic [31:0] reg_value(input logic [4:0] idx);
		reg_value = '0;
		unique case (idx)
			IDX_STRAP: begin
				reg_value[3:0]        = mode_vec;
				reg_value[STRAP_CLKEN] = ref_clock_out_enable_strap_reg;
				reg_value[STRAP_LED]   = led_indication_select_strap_reg;
				reg_value[STRAP_ADDR +: 5] = mgmt_address;
			end
			IDX_WAKE_CFG: reg_value[WAKE_SEL_BIT] = wake_sel_reg;
			IDX_INT_CTRL: begin
				reg_value[EVT_W-1:0] = int_status_reg;
				reg_value[INT_EN_LSB +: EVT_W] = int_en_reg;
			end
			IDX_PHY_CTRL: reg_value[POL_BIT] = pol_reg;
			default: reg_value = '0;
		endcase
	endfunction

	// AXI write channel state
	logic              aw_held_reg;
	logic              w_held_reg;
	logic [ADDR_W-1:0] awaddr_reg;
	logic [31:0]       wdata_reg;
	logic [3:0]        wstrb_reg;
	logic              wr_fire;
	logic [4:0]        wr_idx;
	logic              wr_ok;

	assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
	assign wr_idx  = awaddr_reg[IDX_MSB:IDX_LSB];
	assign wr_ok   = !awaddr_reg[ADDR_W-1] && is_mapped(wr_idx);

	always_comb begin
		evt_clr = '0;
		if (wr_fire && wr_ok && wr_idx == IDX_INT_CTRL && wstrb_reg[0]) begin
			evt_clr = wdata_reg[EVT_W-1:0];
		end
	end

	assign evt_set = {mgmt_evt, wake_event, link_event};
	assign irq_active = |(int_status_reg & int_en_reg);

	// A new event in the clearing cycle survives the clear.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			int_status_reg <= '0;
		end else begin
			int_status_reg <= (int_status_reg & ~evt_clr) | evt_set;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			int_en_reg   <= '0;
			pol_reg      <= 1'h0;
			wake_sel_reg <= 1'h0;
		end else if (wr_fire && wr_ok) begin
			if (wr_idx == IDX_INT_CTRL && wstrb_reg[1]) begin
				int_en_reg <= wdata_reg[INT_EN_LSB +: EVT_W];
			end
			if (wr_idx == IDX_PHY_CTRL && wstrb_reg[1]) begin
				pol_reg <= wdata_reg[POL_BIT];
			end
			if (wr_idx == IDX_WAKE_CFG && wstrb_reg[0]) begin
				wake_sel_reg <= wdata_reg[WAKE_SEL_BIT];
			end
		end
	end

	// The pin is a plain push-pull output in both functions.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq              <= 1'h0;
			wake_event_out_n <= 1'h1;
		end else begin
			irq <= irq_active;
			if (wake_sel_reg) begin
				wake_event_out_n <= !int_status_reg[EVT_WAKE];
			end else begin
				wake_event_out_n <= pol_reg ~^ irq_active;
			end
		end
	end

	// ==========================================================
	// AXI4-Lite handshakes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg   <= 1'h0;
			s_axi_awready <= 1'h0;
			awaddr_reg    <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_reg   <= 1'h1;
			s_axi_awready <= 1'h0;
			awaddr_reg    <= s_axi_awaddr;
		end else if (s_axi_bvalid && s_axi_bready) begin
			aw_held_reg   <= 1'h0;
			s_axi_awready <= 1'h1;
		end else if (!aw_held_reg) begin
			s_axi_awready <= 1'h1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_reg   <= 1'h0;
			s_axi_wready <= 1'h0;
			wdata_reg    <= '0;
			wstrb_reg    <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_reg   <= 1'h1;
			s_axi_wready <= 1'h0;
			wdata_reg    <= s_axi_wdata;
			wstrb_reg    <= s_axi_wstrb;
		end else if (s_axi_bvalid && s_axi_bready) begin
			w_held_reg   <= 1'h0;
			s_axi_wready <= 1'h1;
		end else if (!w_held_reg) begin
			s_axi_wready <= 1'h1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'h0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'h1;
			s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'h0;
		end
	end

	logic [4:0] rd_idx;
	logic       rd_ok;

	assign rd_idx = s_axi_araddr[IDX_MSB:IDX_LSB];
	assign rd_ok  = !s_axi_araddr[ADDR_W-1] && is_mapped(rd_idx);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'h0;
			s_axi_rvalid  <= 1'h0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'h0;
			s_axi_rvalid  <= 1'h1;
			s_axi_rdata   <= rd_ok ? reg_value(rd_idx) : '0;
			s_axi_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'h0;
			s_axi_arready <= 1'h1;
		end else if (!s_axi_rvalid) begin
			s_axi_arready <= 1'h1;
		end
	end

	// ==========================================================
	// Management frame responder
	// Frames are read-only here; a write addressed to this device only
	// raises the management event, which keeps one writer per register.
	slip_mgmt_state_type mg_state_reg;
	logic [5:0]          pre_cnt_reg;
	logic [4:0]          bit_cnt_reg;
	logic [12:0]         hdr_reg;
	logic [15:0]         tx_reg;
	logic                mdc_rise;
	logic                mdio_s;
	logic                hdr_match;
	logic [31:0]         mg_word;

	assign mdio_s    = mgmt_sync[0];
	assign mdc_rise  = mgmt_sync[1] && !mdc_d_reg;
	assign hdr_match = hdr_reg[11] && (hdr_reg[8:4] == mgmt_address);
	assign mgmt_evt  = mdc_rise && mg_state_reg == MG_HEADER &&
	                   bit_cnt_reg == HDR_BITS - 5'h01 &&
	                   hdr_match && hdr_reg[10:9] == OP_WRITE;

	// The reply word is looked up while the last address bit is still on
	// the shifter input, so the data is ready for the turnaround edge.
	always_comb begin
		mg_word = reg_value({hdr_reg[3:0], mdio_s});
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mdc_d_reg <= 1'h0;
		end else begin
			mdc_d_reg <= mgmt_sync[1];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mg_state_reg <= MG_PREAMBLE;
			pre_cnt_reg  <= '0;
			bit_cnt_reg  <= '0;
			hdr_reg      <= '0;
			tx_reg       <= '0;
			mdio_out     <= 1'h0;
			mdio_oe      <= 1'h0;
		end else if (mdc_rise) begin
			unique case (mg_state_reg)
				MG_PREAMBLE: begin
					if (mdio_s) begin
						if (pre_cnt_reg != PREAMBLE_LEN) begin
							pre_cnt_reg <= pre_cnt_reg + 6'h01;
						end
					end else begin
						if (pre_cnt_reg == PREAMBLE_LEN) begin
							mg_state_reg <= MG_HEADER;
						end
						pre_cnt_reg <= '0;
						bit_cnt_reg <= '0;
					end
				end
				MG_HEADER: begin
					hdr_reg     <= {hdr_reg[11:0], mdio_s};
					bit_cnt_reg <= bit_cnt_reg + 5'h01;
					if (bit_cnt_reg == HDR_BITS - 5'h01) begin
						bit_cnt_reg <= '0;
						if (hdr_match && hdr_reg[10:9] == OP_READ) begin
							mg_state_reg <= MG_TURN;
							tx_reg       <= mg_word[15:0];
						end else begin
							mg_state_reg <= MG_SKIP;
						end
					end
				end
				MG_TURN: begin
					mdio_oe      <= 1'h1;
					mdio_out     <= 1'h0;
					mg_state_reg <= MG_DATA;
				end
				MG_DATA: begin
					bit_cnt_reg <= bit_cnt_reg + 5'h01;
					if (bit_cnt_reg == DATA_BITS) begin
						mdio_oe      <= 1'h0;
						mg_state_reg <= MG_PREAMBLE;
					end else begin
						mdio_out <= tx_reg[15];
						tx_reg   <= {tx_reg[14:0], 1'h0};
					end
				end
				MG_SKIP: begin
					bit_cnt_reg <= bit_cnt_reg + 5'h01;
					if (bit_cnt_reg == SKIP_BITS - 5'h01) begin
						mg_state_reg <= MG_PREAMBLE;
					end
				end
			endcase
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_capture_edge;
		!captured_reg ##1 captured_reg;
	endsequence

	a_straps_held: assert property (
		captured_reg && $past(captured_reg) |-> $stable(mode_vec) &&
		$stable(mgmt_address_strap_bit2_reg))
		else $error("strap value changed after capture");

	a_strap_sample: assert property (
		!captured_reg |=> mode_vec == $past(strap_sync[3:0]) &&
		ref_clock_out_enable_strap_reg == $past(strap_sync[4]))
		else $error("strap not taken at reset release");

	a_pins_after_cap: assert property (
		s_capture_edge |-> rxd_pin_oe == 4'hF && rx_ctl_pin_oe && rxc_pin_oe)
		else $error("receive pins not driven after capture");

	a_pins_track_data: assert property (
		captured_reg |=> rxd_pin_out == $past(rx_data))
		else $error("receive data pins do not follow source");

	a_ref_clk_enable: assert property (
		s_capture_edge ##1 1'h1 |-> ref_clock_out_oe ==
		ref_clock_out_enable_strap_reg)
		else $error("reference clock enable does not follow strap");

	a_mode_decode: assert property (
		captured_reg |=> nand_tree_mode == ($past(mode_vec) == MODE_NAND_TREE) &&
		chip_power_down == ($past(mode_vec) == MODE_POWER_DOWN))
		else $error("mode strap decode wrong");

	a_addr_top_zero: assert property (
		mgmt_address[4:3] == 2'h0)
		else $error("management address top bits not zero");

	a_irq_polarity: assert property (
		!wake_sel_reg && $stable(wake_sel_reg) |=>
		wake_event_out_n == ($past(pol_reg) ? $past(irq_active)
		                                    : !$past(irq_active)))
		else $error("interrupt pin polarity wrong");

	a_wake_low: assert property (
		wake_sel_reg && int_status_reg[EVT_WAKE] && $stable(wake_sel_reg)
		|=> !wake_event_out_n)
		else $error("wake pin not low on wake event");

	a_irq_level: assert property (
		$rose(int_status_reg[EVT_LINK]) && int_en_reg[EVT_LINK] |=> irq)
		else $error("enabled event did not raise interrupt");

	a_mgmt_on_edge: assert property (
		$rose(mdio_oe) || $fell(mdio_oe) |-> $past(mdc_rise))
		else $error("management drive moved off clock edge");

endmodule
`default_nettype wire

// file: tb/slip_mgmt_station.sv
// Purpose: Management station model that drives MDC and the MDIO headers of read and write frames.
// Assumes: MDIO has a pull-up; MDC stands low outside frames.
// Notes:   Bit time 160 ns; reply bits are sampled late in MDC high.
`timescale 1ns/10ps
`default_nettype none
module slip_mgmt_station
	import slip_pkg::*;
(
	// Management pins
	output var logic  mdc,
	output wire logic mdio_in,
	input  wire logic mdio_out,
	input  wire logic mdio_oe
);
	logic sta_oe = 1'b0;
	logic sta_d = 1'b0;
	initial mdc = 1'b0;
	// A released line floats up to the pull-up level.
	assign mdio_in = mdio_oe ? mdio_out : (sta_oe ? sta_d : 1'b1);

	task automatic frame(input logic [1:0] op, input logic [4:0] phy, ra,
		output logic [15:0] d, output logic ta);
		logic [45:0] bits;
		// Offset from the bench clock so pins never move on its edge.
		#3;
		bits = {32'hFFFF_FFFF, 2'h1, op, phy, ra};
		sta_oe = 1'b1;
		for (int i = 45; i >= 0; i--) begin
			sta_d = bits[i];
			#80 mdc = 1'b1;
			#80 mdc = 1'b0;
		end
		sta_oe = 1'b0;
		for (int i = 0; i <= 17; i++) begin
			#80 mdc = 1'b1;
			#70;
			if (i == 0)
				ta = mdio_in;
			else if (i <= 16)
				d[16-i] = mdio_in;
			#10 mdc = 1'b0;
		end
	endtask
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// Purpose: Self-checking bench for the strap latch and interrupt pin block.
// Assumes: Undriven shared pins resolve to the bench's strap pulls.
// Notes:   Registers go over AXI4-Lite; frames come from the station.
`timescale 1ns/10ps
`default_nettype none
module tb_top
	import slip_pkg::*;
;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0, rdata, rd;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, rs;
	logic [3:0] rx_data = 4'h0, st_rxd = 4'h7, rxd_out, rxd_oe, rxd_in;
	logic st_ctl = 1'b1, st_rxc = 1'b1, st_ref = 1'b1;
	logic link_ev = 1'b0, wake_ev = 1'b0;
	logic [1:0] addr_low = 2'h1;
	logic ctl_out, ctl_oe, rxc_out, rxc_oe, ref_out, ref_oe;
	logic mdc, mdio_in, mdio_out, mdio_oe, wake_n, irq, ntree, pdown;
	logic led, sdone, ta;
	logic [4:0] maddr;
	logic [15:0] md;
	int fails = 0, checks = 0;

	always #5 aclk = ~aclk;
	assign rxd_in = (rxd_oe & rxd_out) | (~rxd_oe & st_rxd);

	slip_mgmt_station i_sta (.mdc(mdc), .mdio_in(mdio_in),
		.mdio_out(mdio_out), .mdio_oe(mdio_oe));

	slip_top i_dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .rx_data(rx_data), .rx_ctl(rx_data[3]),
		.rx_clk_src(rx_data[2]), .ref_clk_src(rx_data[1]),
		.mgmt_addr_low(addr_low),
		.link_event(link_ev), .wake_event(wake_ev), .rxd_pin_in(rxd_in),
		.rxd_pin_out(rxd_out), .rxd_pin_oe(rxd_oe),
		.rx_ctl_pin_in(ctl_oe ? ctl_out : st_ctl), .rx_ctl_pin_out(ctl_out),
		.rx_ctl_pin_oe(ctl_oe), .rxc_pin_in(rxc_oe ? rxc_out : st_rxc),
		.rxc_pin_out(rxc_out), .rxc_pin_oe(rxc_oe),
		.ref_clock_out_pin_in(ref_oe ? ref_out : st_ref),
		.ref_clock_out(ref_out), .ref_clock_out_oe(ref_oe), .mdc(mdc),
		.mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
		.wake_event_out_n(wake_n), .irq(irq), .mgmt_address(maddr),
		.nand_tree_mode(ntree), .chip_power_down(pdown),
		.led_indication_select(led), .strap_done(sdone));

	task automatic close_out;
		if (fails == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, g);
		checks++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", nm, e, g);
			fails++;
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			n++;
			if (n > 40) begin
				fails++;
				close_out();
			end
		end while (!bvalid);
		// Ready stays high between transfers, so back-to-back calls never
		// drive it twice in one time step.
		rs = bresp;
	endtask

	task automatic rdr(input logic [7:0] a);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
			n++;
			if (n > 40) begin
				fails++;
				close_out();
			end
		end while (!rvalid);
		rd = rdata;
		rs = rresp;
	endtask

	task automatic do_reset;
		aresetn <= 1'b0;
		repeat (5) @(posedge aclk);
		chk("oe in reset", 32'h0, {ref_oe, ctl_oe, rxc_oe, rxd_oe});
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
	endtask

	task automatic pulse(input logic wk);
		link_ev <= ~wk;
		wake_ev <= wk;
		@(posedge aclk);
		link_ev <= 1'b0;
		wake_ev <= 1'b0;
		repeat (3) @(posedge aclk);
	endtask

	initial begin
		#300000;
		fails++;
		close_out();
	end

	initial begin
		do_reset();
		chk("strap done", 32'h1, sdone);
		chk("power down", 32'h1, pdown);
		chk("nand tree", 32'h0, ntree);
		chk("mgmt address", 32'h05, maddr);
		chk("led select", 32'h1, led);
		chk("pin oe", 32'h7F, {ref_oe, ctl_oe, rxc_oe, rxd_oe});
		rdr(8'h40);
		chk("strap word", 32'h177, rd);
		rx_data <= 4'hA;
		repeat (2) @(posedge aclk);
		chk("rxd out", 32'hA, rxd_out);
		chk("ctl clk out", 32'h5, {ref_out, rxc_out, ctl_out});
		wr(8'h40, 32'h0);
		chk("strap write resp", RESP_OKAY, rs);
		rdr(8'h40);
		chk("strap held", 32'h177, rd);
		rdr(8'h00);
		chk("unmapped resp", RESP_SLVERR, rs);
		wr(8'h6C, 32'h100);
		pulse(1'b0);
		chk("irq set", 32'h1, irq);
		chk("pin low active", 32'h0, wake_n);
		wr(8'h7C, 32'h4000);
		@(posedge aclk);
		chk("pin high active", 32'h1, wake_n);
		i_sta.frame(OP_READ, 5'h05, 5'h1F, md, ta);
		chk("turnaround", 32'h0, ta);
		chk("frame data", 32'h4000, md);
		@(posedge aclk);
		rdr(8'h6C);
		chk("int status", 32'h101, rd);
		i_sta.frame(OP_WRITE, 5'h05, 5'h00, md, ta);
		chk("write frame idle", 32'h1, ta);
		@(posedge aclk);
		rdr(8'h6C);
		chk("int status mgmt", 32'h105, rd);
		wr(8'h6C, 32'h107);
		repeat (2) @(posedge aclk);
		chk("irq clear", 32'h0, irq);
		chk("pin idle", 32'h0, wake_n);
		wr(8'h44, 32'h1);
		@(posedge aclk);
		chk("wake idle", 32'h1, wake_n);
		pulse(1'b1);
		chk("wake event", 32'h0, wake_n);
		st_rxd <= 4'h4;
		st_ctl <= 1'b0;
		st_rxc <= 1'b0;
		st_ref <= 1'b0;
		do_reset();
		chk("nand tree 2", 32'h1, ntree);
		chk("power down 2", 32'h0, pdown);
		chk("mgmt address 2", 32'h01, maddr);
		chk("ref oe 2", 32'h0, ref_oe);
		chk("led select 2", 32'h0, led);
		close_out();
	end
endmodule
`default_nettype wire
